// ===== design/pepc_event_cell.sv
// One event flag with latch, clear and test forcing
`timescale 1ns/10ps
module pepc_event_cell (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic cond_i,  // Live condition
  input  wire logic test_i,  // Simulated event level
  input  wire logic latch_i, // Hold until cleared
  input  wire logic clear_i, // One-cycle clear pulse
  output logic      flag_o
);
  // State: the sticky part of the flag
  typedef struct packed {
    logic held;
  } pepc_cell_st_t;
  pepc_cell_st_t st_reg;
  pepc_cell_st_t st_next;
  logic          raw;

  // Raw event is real or simulated
  assign raw = cond_i | test_i;

  // Held part: a live event in the clear cycle wins over the clear
  always_comb begin
    st_next = st_reg;
    if (!latch_i) begin
      st_next.held = 1'b0;
    end else if (raw) begin
      st_next.held = 1'b1;
    end else if (clear_i) begin
      st_next.held = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Flag follows the raw event, plus held part when latching
  assign flag_o = raw | st_reg.held;

  cell_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    latch_i && raw ##1 latch_i && !clear_i |-> flag_o)
    else $error("Latched flag dropped without clear");
  cell_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    clear_i && latch_i && !raw ##1 !raw |-> !flag_o)
    else $error("Clear did not clear flag");
endmodule

// ===== design/pepc_map.svh
// Event indices, field positions, implemented mask and reset value for the event pin block
`ifndef PEPC_MAP_SVH
`define PEPC_MAP_SVH
// Event indices: 0 over current, 1 over power, 2 sag, 3 surge
`define PEPC_EV_CUR      0
`define PEPC_EV_POW      1
`define PEPC_EV_SAG      2
`define PEPC_EV_SWL      3
`define PEPC_NUM_EV      4
// Field base positions: 4-bit per-event groups (route and clear not in event order) and the manual bit
`define PEPC_TEST_LSB    0
`define PEPC_LATCH_LSB   4
`define PEPC_CLEAR_LSB   8
`define PEPC_MANUAL_BIT  14
`define PEPC_ROUTE_LSB   16
// Implemented bits of the register
`define PEPC_IMPL_MASK   32'h000f4fff
`define PEPC_CFG_RESET   32'h00000000
// Voltage threshold width
`define PEPC_VW          16
`endif

// ===== design/pepc_pkg.sv
// Types for the event pin block
package pepc_pkg;
  // Per-event vector, bit order by event index
  typedef logic [3:0] pepc_ev_t;
  // Register write request
  typedef struct packed {
    logic        wr;   // One-cycle write strobe
    logic [31:0] data; // Write data
  } pepc_wr_t;
  // Voltage monitor sample and limits
  typedef struct packed {
    logic        ready;       // Data-ready pulse
    logic [15:0] mean_sq;     // Trailing mean-square voltage
    logic [15:0] sag_limit;   // Below this sets sag
    logic [15:0] surge_limit; // Above this sets surge
  } pepc_volt_t;
endpackage

// ===== design/pepc_top.sv
// Event_config register and event output pin control
`timescale 1ns/10ps
`include "pepc_map.svh"
module pepc_top (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire pepc_pkg::pepc_wr_t   cfg_wr_i,       // Register write from serial interface
  output logic [31:0]               cfg_rd_o,       // Register read-back
  input  wire pepc_pkg::pepc_volt_t volt_i,         // Voltage sample and limits
  input  wire logic                 over_current_i, // Over-current condition level
  input  wire logic                 over_power_i,   // Over-power condition level
  output logic                      event_pin_o,    // Event output pin
  output pepc_pkg::pepc_ev_t        flags_o         // Event flags
);
  // All state of this module
  typedef struct packed {
    logic [31:0] cfg; // Stored configuration, clears self-reset
    logic        pin; // Registered pin level
  } pepc_top_st_t;
  pepc_top_st_t       st_reg;
  pepc_top_st_t       st_next;
  pepc_pkg::pepc_ev_t cond;
  pepc_pkg::pepc_ev_t flags;
  pepc_pkg::pepc_ev_t route;
  pepc_pkg::pepc_ev_t clr;
  logic               sag_c;
  logic               surge_c;

  // Pull one 4-bit per-event field out of the register
  function automatic pepc_pkg::pepc_ev_t field4(input logic [31:0] r, input int lsb);
    field4 = r[lsb +: 4];
  endfunction

  // Route field holds sag, surge, current, power from its low bit up;
  // reorder into event index order so cells and pin logic share one map
  function automatic pepc_pkg::pepc_ev_t route_order(input pepc_pkg::pepc_ev_t f);
    route_order = {f[1], f[0], f[3], f[2]};
  endfunction

  // Clear field holds sag, surge, power, current from its low bit up
  function automatic pepc_pkg::pepc_ev_t clear_order(input pepc_pkg::pepc_ev_t f);
    clear_order = {f[1], f[0], f[2], f[3]};
  endfunction

  // Voltage condition detector
  pepc_volt_cmp u_cmp (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .volt_i  (volt_i),
    .sag_o   (sag_c),
    .surge_o (surge_c)
  );

  assign cond  = {surge_c, sag_c, over_power_i, over_current_i};
  // Route and clear groups are not in event order; a plain slice would
  // steer the wrong event to the pin or clear the wrong flag
  assign route = route_order(field4(st_reg.cfg, `PEPC_ROUTE_LSB));
  assign clr   = clear_order(field4(st_reg.cfg, `PEPC_CLEAR_LSB));

  // One cell per event, steered by its test, latch and clear bits
  genvar gi;
  generate
    for (gi = 0; gi < `PEPC_NUM_EV; gi++) begin : g_ev
      pepc_event_cell u_cell (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .cond_i  (cond[gi]),
        .test_i  (st_reg.cfg[`PEPC_TEST_LSB + gi]),
        .latch_i (st_reg.cfg[`PEPC_LATCH_LSB + gi]),
        .clear_i (clr[gi]),
        .flag_o  (flags[gi])
      );
    end
  endgenerate

  // Register update and pin level
  always_comb begin
    st_next = st_reg;
    // Clear bits last one cycle, then drop on their own
    st_next.cfg[`PEPC_CLEAR_LSB +: 4] = 4'h0;
    if (cfg_wr_i.wr) begin
      st_next.cfg = cfg_wr_i.data & `PEPC_IMPL_MASK;
    end
    // Pin is manual level OR routed flags, high active
    st_next.pin = st_reg.cfg[`PEPC_MANUAL_BIT] | (|(flags & route));
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{cfg: `PEPC_CFG_RESET, pin: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_rd_o    = st_reg.cfg;
  assign event_pin_o = st_reg.pin;
  assign flags_o     = flags;

  // Pin tracks manual and routed flags one cycle later
  pin_or_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ##1 event_pin_o == $past(st_reg.cfg[14] | (|(flags & route))))
    else $error("Event pin not OR of manual and routed flags");

  // Manual level alone drives the pin high
  pin_manual_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[14] |=> event_pin_o)
    else $error("Manual high did not drive pin");

  // Over-current routed by bit 18
  cur_route_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    flags[0] && st_reg.cfg[18] |=> event_pin_o)
    else $error("Routed over-current missing on pin");

  // Over-power routed by bit 19
  pow_route_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    flags[1] && st_reg.cfg[19] |=> event_pin_o)
    else $error("Routed over-power missing on pin");

  // Sag routed by bit 16
  sag_route_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    flags[2] && st_reg.cfg[16] |=> event_pin_o)
    else $error("Routed sag missing on pin");

  // Surge routed by bit 17
  swl_route_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    flags[3] && st_reg.cfg[17] |=> event_pin_o)
    else $error("Routed surge missing on pin");

  // Nothing routed and manual low keeps the pin low
  unrouted_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st_reg.cfg[14] && st_reg.cfg[19:16] == 4'h0 |=> !event_pin_o)
    else $error("Pin high with nothing routed");

  // Clear bits never outlive one cycle without a new write
  clr_self_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !cfg_wr_i.wr |=> st_reg.cfg[11:8] == 4'h0)
    else $error("Clear bits did not self-reset");

  // Unimplemented positions always read zero
  rsvd_zero_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cfg_rd_o & ~32'h000f4fff) == 32'h00000000)
    else $error("Unimplemented bits read nonzero");

  // Written word lands masked one cycle later
  cfg_wr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_wr_i.wr |=> cfg_rd_o == ($past(cfg_wr_i.data) & `PEPC_IMPL_MASK))
    else $error("Written word not read back masked");

  // Over-current test bit forces its flag at once
  test_force_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[0] |-> flags[0])
    else $error("Test bit did not force over-current");

  // Clear pulse stands one cycle unless rewritten
  clr_ev_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_wr_i.wr && cfg_wr_i.data[11] |=> st_reg.cfg[11] ##1 !st_reg.cfg[11] || $past(cfg_wr_i.wr))
    else $error("Over-current clear pulse malformed");

  // Over-current event: test, latch, follow, clear, set-wins, unrouted
  cur_test_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[0] |-> flags[0])
    else $error("Over-current test bit ignored");
  // Latched flag holds while no clear stands
  cur_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[4] && flags[0] && !st_reg.cfg[11] ##1 st_reg.cfg[4] |-> flags[0])
    else $error("Latched over-current dropped");
  // Without latch the flag is the raw event
  cur_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st_reg.cfg[4] ##1 !st_reg.cfg[4] |-> flags[0] == (over_current_i | st_reg.cfg[0]))
    else $error("Unlatched over-current not following cause");
  // Clear with no cause empties the flag
  cur_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[11] && !(over_current_i | st_reg.cfg[0])
    ##1 !(over_current_i | st_reg.cfg[0]) |-> !flags[0])
    else $error("Over-current clear ignored");
  // A live event in the clear cycle wins
  cur_wins_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[11] && st_reg.cfg[4] && (over_current_i | st_reg.cfg[0]) |=> flags[0])
    else $error("Over-current lost to clear");
  // Only this flag, unrouted, keeps the pin low
  cur_alone_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    flags == 4'h1 && !st_reg.cfg[18] && !st_reg.cfg[14] |=> !event_pin_o)
    else $error("Unrouted over-current reached pin");

  // Over-power event: test, latch, follow, clear, set-wins, unrouted
  pow_test_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[1] |-> flags[1])
    else $error("Over-power test bit ignored");
  // Latched flag holds while no clear stands
  pow_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[5] && flags[1] && !st_reg.cfg[10] ##1 st_reg.cfg[5] |-> flags[1])
    else $error("Latched over-power dropped");
  // Without latch the flag is the raw event
  pow_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st_reg.cfg[5] ##1 !st_reg.cfg[5] |-> flags[1] == (over_power_i | st_reg.cfg[1]))
    else $error("Unlatched over-power not following cause");
  // Clear with no cause empties the flag
  pow_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[10] && !(over_power_i | st_reg.cfg[1])
    ##1 !(over_power_i | st_reg.cfg[1]) |-> !flags[1])
    else $error("Over-power clear ignored");
  // A live event in the clear cycle wins
  pow_wins_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[10] && st_reg.cfg[5] && (over_power_i | st_reg.cfg[1]) |=> flags[1])
    else $error("Over-power lost to clear");
  // Only this flag, unrouted, keeps the pin low
  pow_alone_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    flags == 4'h2 && !st_reg.cfg[19] && !st_reg.cfg[14] |=> !event_pin_o)
    else $error("Unrouted over-power reached pin");

  // Sag event: test, latch, follow, clear, set-wins, unrouted
  sag_test_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[2] |-> flags[2])
    else $error("Sag test bit ignored");
  // Latched flag holds while no clear stands
  sag_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[6] && flags[2] && !st_reg.cfg[8] ##1 st_reg.cfg[6] |-> flags[2])
    else $error("Latched sag dropped");
  // Without latch the flag is the raw event
  sag_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st_reg.cfg[6] ##1 !st_reg.cfg[6] |-> flags[2] == (sag_c | st_reg.cfg[2]))
    else $error("Unlatched sag not following cause");
  // Clear with no cause empties the flag
  sag_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[8] && !(sag_c | st_reg.cfg[2]) ##1 !(sag_c | st_reg.cfg[2]) |-> !flags[2])
    else $error("Sag clear ignored");
  // A live event in the clear cycle wins
  sag_wins_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[8] && st_reg.cfg[6] && (sag_c | st_reg.cfg[2]) |=> flags[2])
    else $error("Sag lost to clear");
  // Only this flag, unrouted, keeps the pin low
  sag_alone_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    flags == 4'h4 && !st_reg.cfg[16] && !st_reg.cfg[14] |=> !event_pin_o)
    else $error("Unrouted sag reached pin");

  // Surge event: test, latch, follow, clear, set-wins, unrouted
  swl_test_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[3] |-> flags[3])
    else $error("Surge test bit ignored");
  // Latched flag holds while no clear stands
  swl_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[7] && flags[3] && !st_reg.cfg[9] ##1 st_reg.cfg[7] |-> flags[3])
    else $error("Latched surge dropped");
  // Without latch the flag is the raw event
  swl_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st_reg.cfg[7] ##1 !st_reg.cfg[7] |-> flags[3] == (surge_c | st_reg.cfg[3]))
    else $error("Unlatched surge not following cause");
  // Clear with no cause empties the flag
  swl_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[9] && !(surge_c | st_reg.cfg[3]) ##1 !(surge_c | st_reg.cfg[3]) |-> !flags[3])
    else $error("Surge clear ignored");
  // A live event in the clear cycle wins
  swl_wins_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[9] && st_reg.cfg[7] && (surge_c | st_reg.cfg[3]) |=> flags[3])
    else $error("Surge lost to clear");
  // Only this flag, unrouted, keeps the pin low
  swl_alone_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    flags == 4'h8 && !st_reg.cfg[17] && !st_reg.cfg[14] |=> !event_pin_o)
    else $error("Unrouted surge reached pin");

  // Latched over-current outliving its cause
  cov_latch_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[4] && flags[0] && !over_current_i);

  // Clear pulse emptying the over-current flag
  cov_clear_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    st_reg.cfg[11] ##1 !flags[0]);

  // Pin rising edge
  cov_pin_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    !event_pin_o ##1 event_pin_o);

  // Routed sag seen
  cov_sag_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    flags[2] && st_reg.cfg[16]);
endmodule

// ===== design/pepc_volt_cmp.sv
// Voltage sag and surge comparator sampled at each data-ready
`timescale 1ns/10ps
`include "pepc_map.svh"
module pepc_volt_cmp (
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire pepc_pkg::pepc_volt_t volt_i,
  output logic                     sag_o,
  output logic                     surge_o
);
  // State: both conditions held between data-ready pulses
  typedef struct packed {
    logic sag;
    logic surge;
  } pepc_cmp_st_t;
  pepc_cmp_st_t st_reg;
  pepc_cmp_st_t st_next;

  // Compare only on data ready, otherwise hold
  always_comb begin
    st_next = st_reg;
    if (volt_i.ready) begin
      st_next.sag   = volt_i.mean_sq < volt_i.sag_limit;
      st_next.surge = volt_i.mean_sq > volt_i.surge_limit;
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sag_o   = st_reg.sag;
  assign surge_o = st_reg.surge;

  cmp_sag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    volt_i.ready |=> sag_o == $past(volt_i.mean_sq < volt_i.sag_limit))
    else $error("Sag flag wrong after data ready");
  cmp_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !volt_i.ready |=> $stable(surge_o) && $stable(sag_o))
    else $error("Condition changed without data ready");
endmodule

// ===== sim/pepc_host_model.sv
// Host-side model that issues whole-word event_config writes
`timescale 1ns/10ps
module pepc_host_model (
  input  wire logic          clock_i,
  output pepc_pkg::pepc_wr_t cfg_wr_o
);
  // Idle bus carries no strobe
  initial cfg_wr_o = '0;
  // Strobe stands across exactly one rising edge
  task automatic write(input logic [31:0] data);
    @(negedge clock_i);
    cfg_wr_o.wr   = 1'b1;
    cfg_wr_o.data = data;
    @(negedge clock_i);
    cfg_wr_o.wr   = 1'b0;
    // Stale word inverted so nothing can lean on it
    cfg_wr_o.data = ~data;
  endtask
endmodule

// ===== sim/power_event_pin_control_tb.sv
// Self-checking bench for the event pin block
`timescale 1ns/10ps
module power_event_pin_control_tb;
  logic                 clock_i;      // 125 MHz clock
  logic                 rst_n_i;      // Active-low reset
  pepc_pkg::pepc_wr_t   cfg_wr;       // Host write
  logic [31:0]          cfg_rd;       // Read-back
  pepc_pkg::pepc_volt_t volt;         // Voltage sample and limits
  logic                 over_current; // Over-current level
  logic                 over_power;   // Over-power level
  logic                 event_pin;    // Event pin
  pepc_pkg::pepc_ev_t   flags;        // Event flags
  int                   miscompares;  // Mismatch count
  int                   num_checks;   // Comparison count
  // Per-event masks, order cur, pow, sag, surge
  logic [31:0] tst [4] = '{32'h00000001, 32'h00000002, 32'h00000004, 32'h00000008};
  logic [31:0] lat [4] = '{32'h00000010, 32'h00000020, 32'h00000040, 32'h00000080};
  logic [31:0] clr [4] = '{32'h00000800, 32'h00000400, 32'h00000100, 32'h00000200};
  logic [31:0] rte [4] = '{32'h00040000, 32'h00080000, 32'h00010000, 32'h00020000};
  // Free-running clock
  initial clock_i = 1'b0;
  always #4 clock_i = ~clock_i;
  pepc_top pepc_top_i (
    .clock_i        (clock_i),
    .rst_n_i        (rst_n_i),
    .cfg_wr_i       (cfg_wr),
    .cfg_rd_o       (cfg_rd),
    .volt_i         (volt),
    .over_current_i (over_current),
    .over_power_i   (over_power),
    .event_pin_o    (event_pin),
    .flags_o        (flags)
  );
  pepc_host_model pepc_host_model_i (
    .clock_i  (clock_i),
    .cfg_wr_o (cfg_wr)
  );
  // Shared comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // Raise or drop one event's live condition; voltage ones need a data-ready pulse
  task automatic raise(input int i, input logic lvl);
    @(negedge clock_i);
    if (i == 0) begin
      over_current = lvl;
    end else if (i == 1) begin
      over_power = lvl;
    end else begin
      volt.mean_sq = !lvl ? 16'h0240 : (i == 2) ? 16'h0100 : 16'h0300;
      volt.ready   = 1'b1;
      @(negedge clock_i);
      volt.ready   = 1'b0;
    end
    cyc(2);
  endtask
  // Closing verdict, reached from the main flow or the watchdog
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic t_regs();
    chk(cfg_rd, 32'h0);
    chk(32'(event_pin), 32'h0);
    pepc_host_model_i.write(32'hffffffff);
    chk(cfg_rd, 32'h000f4fff);
    cyc(1);
    chk(cfg_rd, 32'h000f40ff);
    chk(32'(event_pin), 32'h1);
    pepc_host_model_i.write(32'h0);
    cyc(2);
    chk(32'(event_pin), 32'h0);
    $display("test regs done");
  endtask
  // Forced events, unrouted then routed, then withdrawn
  task automatic t_test(input int i);
    pepc_host_model_i.write(tst[i]);
    cyc(2);
    chk(32'(flags), 32'h1 << i);
    chk(32'(event_pin), 32'h0);
    pepc_host_model_i.write(tst[i] | rte[i]);
    cyc(2);
    chk(32'(event_pin), 32'h1);
    pepc_host_model_i.write(rte[i]);
    cyc(2);
    chk(32'(flags), 32'h0);
    chk(32'(event_pin), 32'h0);
    $display("test forced event %0d done", i);
  endtask
  // Real event held by latch, then cleared; without latch it follows the cause
  task automatic t_latch(input int i);
    pepc_host_model_i.write(lat[i] | rte[i]);
    raise(i, 1'b1);
    chk(32'(flags), 32'h1 << i);
    raise(i, 1'b0);
    chk(32'(flags), 32'h1 << i);
    chk(32'(event_pin), 32'h1);
    pepc_host_model_i.write(lat[i] | rte[i] | clr[i]);
    chk(cfg_rd, lat[i] | rte[i] | clr[i]);
    cyc(3);
    chk(32'(flags), 32'h0);
    chk(32'(event_pin), 32'h0);
    chk(cfg_rd, lat[i] | rte[i]);
    pepc_host_model_i.write(rte[i]);
    raise(i, 1'b1);
    chk(32'(event_pin), 32'h1);
    raise(i, 1'b0);
    chk(32'(flags), 32'h0);
    $display("test latch event %0d done", i);
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  // Main sequence
  initial begin
    rst_n_i           = 1'b0;
    over_current      = 1'b0;
    over_power        = 1'b0;
    volt.ready        = 1'b0;
    volt.mean_sq      = 16'h0240;
    volt.sag_limit    = 16'h0200;
    volt.surge_limit  = 16'h0280;
    miscompares       = 0;
    num_checks        = 0;
    repeat (12) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_regs();
    for (int i = 0; i < 4; i++) begin
      t_test(i);
      t_latch(i);
    end
    wrap_up();
  end
endmodule
